// file: core/lsqr_responder.v
// Link status query responder with AXI4-Lite control registers
`timescale 1ns/1ns
`include "lsqr_regs.vh"

module lsqr_responder #(
  parameter AN_SUPPORTED = 1
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Parsed query from the packet engine
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [7:0]  cmd_code,
  input  wire        cmd_csum_ok,
  input  wire        cmd_id_ok,
  // Response words to the packet engine
  output wire        rsp_valid,
  input  wire        rsp_ready,
  output reg  [7:0]  rsp_type,
  output reg  [31:0] rsp_codes,
  output reg  [31:0] rsp_link,
  output reg  [31:0] rsp_other,
  output reg  [31:0] rsp_oem,
  // PHY status pins
  input  wire        phy_link_up,
  input  wire        phy_lpi,
  input  wire        phy_serdes,
  input  wire        phy_an_complete,
  input  wire        phy_mode_found,
  input  wire [3:0]  common_best_mode,
  input  wire [7:0]  phy_enh_speed,
  input  wire [31:0] phy_other_ind
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_BUILD = 3'b010;
  localparam [2:0] ST_SEND  = 3'b100;
  localparam       SYNC_W   = 49;

  // ------------------------------------------------------------
  // Address decode shared by read and write paths
  // ------------------------------------------------------------
  function [3:0] dec_sel;
    input [3:0] addr;
    begin
      case (addr)
        `LSQR_CTRL_OFS: dec_sel = 4'h1;
        `LSQR_STAT_OFS: dec_sel = 4'h2;
        `LSQR_OEM_OFS:  dec_sel = 4'h4;
        `LSQR_CNT_OFS:  dec_sel = 4'h8;
        default:        dec_sel = 4'h0;
      endcase
    end
  endfunction

  // Byte-lane merge of write data into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [SYNC_W-1:0] sync1_reg;
  reg  [SYNC_W-1:0] sync2_reg;
  reg  [43:0]       sync3_reg;
  reg  [43:0]       word_reg;
  reg  [2:0]        state_reg;
  reg  [31:0]       ctrl_reg;
  reg  [31:0]       oem_reg;
  reg  [15:0]       acc_cnt_reg;
  reg  [15:0]       drop_cnt_reg;
  reg               aw_held_reg;
  reg  [3:0]        aw_addr_reg;
  reg               w_held_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;
  reg  [3:0]        spd_code;
  reg  [31:0]       link_word;
  reg  [31:0]       rd_word;
  wire              s_link;
  wire              s_lpi;
  wire              s_serdes;
  wire              s_an_cpl;
  wire              s_found;
  wire [3:0]        s_best;
  wire [7:0]        s_enh;
  wire [31:0]       s_other;
  wire              link_flag;
  wire              an_flag;
  wire              an_done;
  wire              query_hit;
  wire              query_good;
  wire              wr_fire;
  wire [3:0]        wr_sel;
  wire [3:0]        rd_sel;
  wire              ar_fire;

  // ------------------------------------------------------------
  // PHY status synchroniser
  // ------------------------------------------------------------
  // Two flops per pin; flag pins use the second stage, word pins a copy updated when two samples agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= {SYNC_W{1'b0}};
      sync2_reg <= {SYNC_W{1'b0}};
      sync3_reg <= 44'h000_0000_0000;
      word_reg  <= 44'h000_0000_0000;
    end else begin
      sync1_reg <= {phy_link_up, phy_lpi, phy_serdes, phy_an_complete,
                    phy_mode_found, common_best_mode, phy_enh_speed,
                    phy_other_ind};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg[43:0];
      if (sync2_reg[43:0] == sync3_reg) begin // Word settled, no torn value
        word_reg <= sync2_reg[43:0];
      end
    end
  end

  assign s_link   = sync2_reg[48];
  assign s_lpi    = sync2_reg[47];
  assign s_serdes = sync2_reg[46];
  assign s_an_cpl = sync2_reg[45];
  assign s_found  = sync2_reg[44];
  assign s_best   = word_reg[43:40];
  assign s_enh    = word_reg[39:32];
  assign s_other  = word_reg[31:0];

  // ------------------------------------------------------------
  // Link-status word
  // ------------------------------------------------------------
  // Low-power idle keeps the link up while energy saving is on
  assign link_flag = s_link | (ctrl_reg[`LSQR_CTRL_EEE_EN] & s_lpi);
  // Negotiation flags read zero when unsupported or disabled
  assign an_flag = (AN_SUPPORTED != 0) & ctrl_reg[`LSQR_CTRL_AN_EN];
  // Completion includes parallel detection, reported by the PHY
  assign an_done = an_flag & s_an_cpl;

  // Speed code selection
  always @* begin
    spd_code = `LSQR_SPD_NONE;
    if (s_serdes) begin
      spd_code = `LSQR_SPD_NONE;
    end else if (!an_flag && ctrl_reg[`LSQR_CTRL_FORCE]) begin
      spd_code = ctrl_reg[`LSQR_CTRL_FSPD_LO +: 4];
    end else if (an_done && s_found) begin
      // Nearest listed code from the PHY, codes 0x1-0xF as is
      spd_code = s_best;
    end else begin
      spd_code = `LSQR_SPD_NONE;
    end
  end

  // Word assembly with enhanced field only behind code 0xF
  always @* begin
    link_word = 32'h0000_0000;
    link_word[`LSQR_LS_LINK_BIT] = link_flag;
    link_word[`LSQR_LS_SPD_HI:`LSQR_LS_SPD_LO] = spd_code;
    link_word[`LSQR_LS_AN_EN_BIT] = an_flag;
    link_word[`LSQR_LS_AN_DONE_BIT] = an_done;
    if (spd_code == `LSQR_SPD_ENHANCED) begin
      link_word[`LSQR_LS_ENH_LO +: 8] = s_enh;
    end
  end

  // ------------------------------------------------------------
  // Query handling
  // ------------------------------------------------------------
  assign cmd_ready  = state_reg[0];
  assign rsp_valid  = state_reg[2];
  assign query_hit  = cmd_valid & cmd_ready
                    & (cmd_code == `LSQR_CMD_GET_LINK);
  assign query_good = query_hit & cmd_csum_ok & cmd_id_ok;

  // Response state machine
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (query_good) begin
            state_reg <= ST_BUILD;
          end
        end
        ST_BUILD: begin
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (rsp_ready) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Response snapshot taken once per accepted query
  always @(posedge aclk) begin
    if (!aresetn) begin
      rsp_type  <= 8'h00;
      rsp_codes <= 32'h0000_0000;
      rsp_link  <= 32'h0000_0000;
      rsp_other <= 32'h0000_0000;
      rsp_oem   <= 32'h0000_0000;
    end else if (state_reg == ST_BUILD) begin
      rsp_type  <= `LSQR_RSP_GET_LINK;
      rsp_codes <= {`LSQR_RSP_COMPLETED, `LSQR_REASON_NONE};
      rsp_link  <= link_word;
      rsp_other <= s_other;
      rsp_oem   <= oem_reg;
    end
  end

  // Accepted and dropped query counters
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_cnt_reg  <= 16'h0000;
      drop_cnt_reg <= 16'h0000;
    end else begin
      if (query_good) begin
        acc_cnt_reg <= acc_cnt_reg + 16'h0001;
      end
      if (query_hit && !query_good) begin
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_sel        = dec_sel(aw_addr_reg);

  // Address and data captured in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Register update and write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= `LSQR_CTRL_RST;
      oem_reg      <= `LSQR_OEM_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LSQR_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        if (wr_sel[0]) begin
          ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg)
                    & 32'h0000_00F7;
        end
        if (wr_sel[2]) begin
          oem_reg <= merge(oem_reg, w_data_reg, w_strb_reg);
        end
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == 4'h0) ? `LSQR_RESP_SLVERR
                                         : `LSQR_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_sel        = dec_sel(s_axi_araddr);

  // Read multiplexer
  always @* begin
    case (rd_sel)
      4'h1:    rd_word = ctrl_reg;
      4'h2:    rd_word = link_word;
      4'h4:    rd_word = oem_reg;
      4'h8:    rd_word = {drop_cnt_reg, acc_cnt_reg};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LSQR_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_sel == 4'h0) ? `LSQR_RESP_SLVERR
                                       : `LSQR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: core/lsqr_regs.vh
// Constants for the link status query responder
// How it works
// - Every 0x0A query gets a 0x8A response unless checksum or identifier fails.
// - Reply bytes: codes 16-19, status 20-23, other 24-27, OEM 28-31.
// - Link-status bit 0 is always built: 0 link down, 1 link up.
// - With energy saving enabled, low-power idle never reads as link down.
// - Speed code 0 if negotiation incomplete, serializer set, no common mode.
// - Codes: 10 half 1, 10 full 2, 100TX half 3, T4 4, TX full 5, 1G half 6.
// - Codes: 10G 8, 20G 9, 25G A, 40G B, 50G C, 100G D, 2.5G E.
// - Code 0xF points to the enhanced speed field from bit 24.
// - With serializer clear, a forced link setting may be reported.
// - Unlisted media may show the nearest code; no media guess from it.
// - Bit 5 shows negotiation enabled; 0 if unsupported or disabled.
// - Bit 6 shows negotiation complete, parallel detection included.
`ifndef LSQR_REGS_VH
`define LSQR_REGS_VH

// ------------------------------------------------------------
// Command and response codes
// ------------------------------------------------------------
`define LSQR_CMD_GET_LINK   8'h0A
`define LSQR_RSP_GET_LINK   8'h8A
`define LSQR_RSP_COMPLETED  16'h0000
`define LSQR_REASON_NONE    16'h0000

// ------------------------------------------------------------
// Byte offsets of fields in the query and response packets
// ------------------------------------------------------------
`define LSQR_Q_CSUM_OFS     6'h10
`define LSQR_Q_PAD_OFS      6'h14
`define LSQR_R_CODES_OFS    6'h10
`define LSQR_R_LINK_OFS     6'h14
`define LSQR_R_OTHER_OFS    6'h18
`define LSQR_R_OEM_OFS      6'h1C
`define LSQR_R_CSUM_OFS     6'h20
`define LSQR_R_PAD_OFS      6'h24
`define LSQR_PKT_LAST       6'h2D

// ------------------------------------------------------------
// Link-status word fields
// ------------------------------------------------------------
`define LSQR_LS_LINK_BIT    0
`define LSQR_LS_SPD_LO      1
`define LSQR_LS_SPD_HI      4
`define LSQR_LS_AN_EN_BIT   5
`define LSQR_LS_AN_DONE_BIT 6
`define LSQR_LS_ENH_LO      24

// ------------------------------------------------------------
// Speed and duplex codes
// ------------------------------------------------------------
`define LSQR_SPD_NONE       4'h0
`define LSQR_SPD_10HD       4'h1
`define LSQR_SPD_10FD       4'h2
`define LSQR_SPD_100TXHD    4'h3
`define LSQR_SPD_100T4      4'h4
`define LSQR_SPD_100TXFD    4'h5
`define LSQR_SPD_1000HD     4'h6
`define LSQR_SPD_1000FD     4'h7
`define LSQR_SPD_10G        4'h8
`define LSQR_SPD_2G5        4'hE
`define LSQR_SPD_ENHANCED   4'hF

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LSQR_CTRL_OFS       4'h0
`define LSQR_STAT_OFS       4'h4
`define LSQR_OEM_OFS        4'h8
`define LSQR_CNT_OFS        4'hC

// ------------------------------------------------------------
// Control fields and reset values
// ------------------------------------------------------------
`define LSQR_CTRL_AN_EN     0
`define LSQR_CTRL_EEE_EN    1
`define LSQR_CTRL_FORCE     2
`define LSQR_CTRL_FSPD_LO   4
`define LSQR_CTRL_RST       32'h0000_0003
`define LSQR_OEM_RST        32'h0000_0000
`define LSQR_RESP_OKAY      2'h0
`define LSQR_RESP_SLVERR    2'h2

`endif

// file: testbench/lsqr_checker.sv
// Checker for query timing and link-status word of the responder
`timescale 1ns/1ns
`include "lsqr_regs.vh"

module lsqr_checker (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Query side
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [7:0]  cmd_code,
  input wire        cmd_csum_ok,
  input wire        cmd_id_ok,
  // Response side
  input wire        rsp_valid,
  input wire        rsp_ready,
  input wire [7:0]  rsp_type,
  input wire [31:0] rsp_codes,
  input wire [31:0] rsp_link,
  // Status pins
  input wire        phy_link_up,
  input wire        phy_serdes,
  input wire        phy_an_complete
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Offers split into good and refused
  wire offer = cmd_valid && cmd_ready;
  wire good  = cmd_code == `LSQR_CMD_GET_LINK && cmd_csum_ok && cmd_id_ok;

  sequence build_then_send;
    (!cmd_ready && !rsp_valid) ##1 rsp_valid;
  endsequence
  sequence loaded;
    $rose(rsp_valid);
  endsequence

  accept_timing_a: assert property (
    offer && good |=> build_then_send)
    else $error("accepted query not answered on time");
  refuse_quiet_a: assert property (
    offer && !good |=> (!rsp_valid)[*3])
    else $error("refused query got a response");
  rsp_type_a: assert property (
    rsp_valid |-> rsp_type == `LSQR_RSP_GET_LINK)
    else $error("wrong response type");
  rsp_codes_a: assert property (
    rsp_valid |-> rsp_codes == {`LSQR_RSP_COMPLETED, `LSQR_REASON_NONE})
    else $error("wrong response and reason codes");
  rsp_hold_a: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_link))
    else $error("response changed while stalled");
  link_up_a: assert property (
    phy_link_up[*6] ##1 loaded |-> rsp_link[0])
    else $error("link up reported as down");
  serdes_zero_a: assert property (
    phy_serdes[*6] ##1 loaded |-> rsp_link[4:1] == `LSQR_SPD_NONE)
    else $error("speed code not zero with serializer set");
  an_idle_a: assert property (
    (!phy_an_complete)[*6] ##1 loaded |-> !rsp_link[6])
    else $error("negotiation done flag without completion");
  an_order_a: assert property (
    rsp_valid && rsp_link[6] |-> rsp_link[5])
    else $error("done flag set with negotiation flag clear");
  enh_zero_a: assert property (
    rsp_valid && rsp_link[4:1] != `LSQR_SPD_ENHANCED
      |-> rsp_link[31:24] == 8'h00)
    else $error("enhanced field set without code 0xF");
endmodule

bind lsqr_responder lsqr_checker chk_i (
  .aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_csum_ok(cmd_csum_ok),
  .cmd_id_ok(cmd_id_ok), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
  .rsp_type(rsp_type), .rsp_codes(rsp_codes), .rsp_link(rsp_link),
  .phy_link_up(phy_link_up), .phy_serdes(phy_serdes),
  .phy_an_complete(phy_an_complete)
);

// file: testbench/lsqr_engine.sv
// Packet engine model: offers parsed queries, takes responses
`timescale 1ns/1ns

module lsqr_engine (
  // Clock
  input  wire        aclk,
  // Parsed query
  output logic       cmd_valid,
  input  wire        cmd_ready,
  output logic [7:0] cmd_code,
  output logic       cmd_csum_ok,
  output logic       cmd_id_ok,
  // Response handshake
  input  wire        rsp_valid,
  output logic       rsp_ready
);
  // Idle levels at time zero
  initial begin
    cmd_valid = 0;
    cmd_code = 8'h00;
    cmd_csum_ok = 0;
    cmd_id_ok = 0;
    rsp_ready = 0;
  end

  // One query, then a stall of dly cycles before taking the answer
  // Speed code is never read here to guess the medium
  task query(input logic [7:0] c, input logic cs, input logic id,
             input int dly, output logic got);
    int n;
    got = 0;
    cmd_code <= c;
    cmd_csum_ok <= cs;
    cmd_id_ok <= id;
    cmd_valid <= 1;
    do @(posedge aclk); while (!cmd_ready);
    cmd_valid <= 0;
    cmd_code <= ~c;
    cmd_csum_ok <= ~cs;
    cmd_id_ok <= ~id;
    for (n = 0; n < 8 && !got; n++) begin
      @(posedge aclk);
      got = rsp_valid;
    end
    if (got) begin
      repeat (dly) @(posedge aclk);
      rsp_ready <= 1;
      @(posedge aclk);
      rsp_ready <= 0;
    end
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the link status query responder
`timescale 1ns/1ns
`include "lsqr_regs.vh"

module tb;
  // Bus, query and pin signals
  logic        aclk = 0, aresetn = 0, g;
  logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hF, mode = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, up = 0, lpi = 0, sd = 0, anc = 0, fnd = 0;
  logic [7:0]  enh = 0;
  logic [31:0] wdata = 0, oth = 32'hA5C3_0F96, d;
  logic [1:0]  r;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, rsp_codes, rsp_link, rsp_other, rsp_oem;
  wire         cmd_valid, cmd_ready, cmd_csum_ok, cmd_id_ok;
  wire         rsp_valid, rsp_ready;
  wire  [7:0]  cmd_code, rsp_type;
  int          failures = 0, samples_checked = 0, acc = 0;

  always #20 aclk = ~aclk;

  lsqr_responder dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_csum_ok(cmd_csum_ok), .cmd_id_ok(cmd_id_ok),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_type(rsp_type),
    .rsp_codes(rsp_codes), .rsp_link(rsp_link), .rsp_other(rsp_other),
    .rsp_oem(rsp_oem), .phy_link_up(up), .phy_lpi(lpi), .phy_serdes(sd),
    .phy_an_complete(anc), .phy_mode_found(fnd), .common_best_mode(mode),
    .phy_enh_speed(enh), .phy_other_ind(oth)
  );

  lsqr_engine eng (
    .aclk(aclk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_csum_ok(cmd_csum_ok), .cmd_id_ok(cmd_id_ok),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready)
  );

  // ------
  // Helpers
  // ------
  function logic [31:0] lw(input logic l, input logic [3:0] s,
                           input logic an, input logic dn);
    lw = {(s == 4'hF) ? enh : 8'h00, 17'h0, dn, an, s, l};
  endfunction

  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, v);
      failures++;
    end
  endtask

  task axw(input logic [3:0] a, input logic [31:0] dv,
           output logic [1:0] rs);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask

  task axr(input logic [3:0] a, output logic [31:0] dv,
           output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    dv = rdata;
    rs = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask

  task give_verdict;
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task t_regs;
    axr(`LSQR_CTRL_OFS, d, r);
    chk("ctrl_rst", `LSQR_CTRL_RST, d);
    axr(`LSQR_OEM_OFS, d, r);
    chk("oem_rst", `LSQR_OEM_RST, d);
    axw(`LSQR_CTRL_OFS, 32'hFFFF_FFFF, r);
    axr(`LSQR_CTRL_OFS, d, r);
    chk("ctrl_rsv", 32'h0000_00F7, d);
    axw(`LSQR_CTRL_OFS, `LSQR_CTRL_RST, r);
    axw(`LSQR_OEM_OFS, 32'h1234_5678, r);
    axr(4'h1, d, r);
    chk("unmap_data", 32'h0000_0000, d);
    chk("unmap_rd", {30'h0, `LSQR_RESP_SLVERR}, {30'h0, r});
    axw(4'h1, 32'hFFFF_FFFF, r);
    chk("unmap_wr", {30'h0, `LSQR_RESP_SLVERR}, {30'h0, r});
  endtask

  task t_codes;
    int k;
    up <= 1;
    anc <= 1;
    fnd <= 1;
    enh <= 8'h3C;
    for (k = 1; k < 16; k++) begin
      mode <= k[3:0];
      repeat (4) @(posedge aclk);
      eng.query(`LSQR_CMD_GET_LINK, 1, 1, k % 3, g);
      acc++;
      chk("got", 1, g);
      chk("type", `LSQR_RSP_GET_LINK, rsp_type);
      chk("codes", 0, rsp_codes);
      chk("other", oth, rsp_other);
      chk("oem", 32'h1234_5678, rsp_oem);
      chk("link", lw(1, k[3:0], 1, 1), rsp_link);
    end
  endtask

  task t_zero;
    int k;
    mode <= `LSQR_SPD_10G;
    for (k = 0; k < 3; k++) begin
      anc <= (k != 0);
      sd <= (k == 1);
      fnd <= (k != 2);
      repeat (4) @(posedge aclk);
      eng.query(`LSQR_CMD_GET_LINK, 1, 1, 0, g);
      acc++;
      chk("zero_spd", lw(1, 4'h0, 1, k != 0), rsp_link);
    end
    sd <= 0;
    fnd <= 1;
  endtask

  task t_link;
    up <= 0;
    lpi <= 1;
    repeat (4) @(posedge aclk);
    eng.query(`LSQR_CMD_GET_LINK, 1, 1, 2, g);
    chk("lpi_eee", lw(1, `LSQR_SPD_10G, 1, 1), rsp_link);
    axw(`LSQR_CTRL_OFS, 32'h0000_0074, r);
    repeat (2) @(posedge aclk);
    eng.query(`LSQR_CMD_GET_LINK, 1, 1, 1, g);
    chk("forced", lw(0, `LSQR_SPD_1000FD, 0, 0), rsp_link);
    axr(`LSQR_STAT_OFS, d, r);
    chk("status", lw(0, `LSQR_SPD_1000FD, 0, 0), d);
    axw(`LSQR_CTRL_OFS, `LSQR_CTRL_RST, r);
    acc += 2;
  endtask

  task t_drop;
    eng.query(`LSQR_CMD_GET_LINK, 0, 1, 0, g);
    chk("bad_csum", 0, g);
    eng.query(`LSQR_CMD_GET_LINK, 1, 0, 0, g);
    chk("bad_id", 0, g);
    eng.query(8'h0B, 1, 1, 0, g);
    chk("other_cmd", 0, g);
    axr(`LSQR_CNT_OFS, d, r);
    chk("counts", {16'h0002, acc[15:0]}, d);
  endtask

  // Reset, scenarios, verdict
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs;
    t_codes;
    t_zero;
    t_link;
    t_drop;
    give_verdict;
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
endmodule
